// ===== hdl/ucfb_pkg.sv
// Constants, types and helper functions shared by the serial-to-CAN bridge.
// Assumes one 40 MHz clock; the CAN controller and UART shifters sit outside.
//
// Summary of operation
// - Standard 11-bit or extended 29-bit identifiers selectable.
// - Nine preset CAN bit rates selectable.
// - Unreachable user rate runs at nearest rate.
// - Sample point and jump width are configurable.
// - Received identifiers pass code and mask filter.
// - Normal mode accepts only well-formed command strings.
// - Normal mode emits received frames as strings.
// - Pair mode sends serial bytes under fixed identifier.
// - Listen-only mode never drives the CAN bus.
// - Pair mode optionally emits identifier with data.
// - Pair mode appends no end characters to CAN-sourced data.
// - End sequence completes buffer, sending starts immediately.
// - Without end character, timeout or full buffer sends.
// - End choices: CR, LF, CR-LF, LF-CR.
// - One or two user bytes as end sequence.
// - CAN timeout delays serial output; zero none.
// - Serial timeout restarts per byte, only without ends.

package ucfb_pkg;

	// ----------------------------------------
	// Clock and time
	// ----------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_TIME_NS = 1_000_000;
	localparam int MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
	localparam int TQ_PER_BIT_DEF = 16;
	localparam logic [4:0] SAMPLE_TQ_RST = 5'h0E;
	localparam logic [1:0] SJW_RST = 2'h1;
	localparam logic [15:0] PRESCALER_RST = 16'h0014;

	// ----------------------------------------
	// Characters
	// ----------------------------------------
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_STD = 8'h74;
	localparam logic [7:0] CH_EXT = 8'h65;
	localparam logic [28:0] STD_ID_MASK = 29'h0000_07FF;
	localparam logic [3:0] MAX_DLC = 4'h8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {MODE_NORMAL, MODE_PAIR, MODE_LISTEN} ucfb_mode_t;
	typedef enum logic [2:0] {END_NONE, END_CR, END_LF, END_CRLF, END_LFCR,
		END_USER1, END_USER2} ucfb_end_t;

	typedef struct packed {
		logic ext;
		logic [28:0] id;
		logic [3:0] dlc;
		logic [63:0] data;
	} ucfb_frame_t;

	typedef struct packed {
		logic [15:0] prescaler;
		logic [4:0] tseg1;
		logic [4:0] tseg2;
		logic [1:0] resync_jump_width;
	} ucfb_timing_t;

	// Preset rates in bit/s; index 8 is the 83.3k setting
	function automatic logic [19:0] presetRate(input logic [3:0] sel);
		case (sel)
			4'h0: presetRate = 20'd10_000;
			4'h1: presetRate = 20'd20_000;
			4'h2: presetRate = 20'd50_000;
			4'h3: presetRate = 20'd125_000;
			4'h4: presetRate = 20'd250_000;
			4'h5: presetRate = 20'd500_000;
			4'h6: presetRate = 20'd800_000;
			4'h7: presetRate = 20'd1_000_000;
			4'h8: presetRate = 20'd83_333;
			default: presetRate = 20'd125_000;
		endcase
	endfunction

	function automatic logic [7:0] hexChar(input logic [3:0] n);
		hexChar = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	// Bit 4 flags a valid hex digit
	function automatic logic [4:0] hexVal(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			hexVal = {1'b1, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
			hexVal = {1'b1, c[3:0] + 4'h9};
		end else begin
			hexVal = 5'h00;
		end
	endfunction

endpackage

// ===== hdl/ucfb_ms_timeout.sv
// Millisecond timeout: a cycle prescaler feeding a saturating ms count.
// Assumes restart is a same-clock pulse; limit zero reads expired at once.
`timescale 1ns/1ps

module ucfb_ms_timeout import ucfb_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic restart,
	input wire logic [15:0] limitMs,
	output logic expired
);

	typedef struct packed {
		logic [15:0] pre;
		logic [15:0] ms;
	} ucfb_tmo_t;

	ucfb_tmo_t st;
	ucfb_tmo_t next_st;

	// ----------------------------------------
	// Tick and count
	// ----------------------------------------
	always_comb begin
		next_st = st;
		if (restart) begin
			next_st = '0;
		end else if (st.ms != 16'hFFFF) begin
			if (st.pre == 16'(MS_CYCLES - 1)) begin
				next_st.pre = 16'h0000;
				next_st.ms = st.ms + 16'h0001;
			end else begin
				next_st.pre = st.pre + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign expired = (st.ms >= limitMs);

endmodule

// ===== hdl/ucfb_bit_timing.sv
// Bit timing: turns a rate choice into prescaler and segment lengths.
// Assumes settings are quasi-static; results settle one clock after a change.
`timescale 1ns/1ps

module ucfb_bit_timing import ucfb_pkg::*; #(
	parameter int TQ_PER_BIT = TQ_PER_BIT_DEF
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] rateSel,
	input wire logic useUserRate,
	input wire logic [19:0] userRateBps,
	input wire logic [4:0] samplePointTq,
	input wire logic [1:0] resyncJumpWidth,
	output ucfb_timing_t timing
);

	typedef struct packed {
		ucfb_timing_t t;
	} ucfb_bt_t;

	localparam logic [4:0] TQ = 5'(TQ_PER_BIT);

	ucfb_bt_t st;
	ucfb_bt_t next_st;
	logic [19:0] rate;
	logic [31:0] den;
	logic [31:0] quo;
	logic [4:0] sp;

	// ----------------------------------------
	// Divider and segments
	// ----------------------------------------
	always_comb begin
		next_st = st;
		rate = useUserRate ? userRateBps : presetRate(rateSel);
		if (rate == 20'h0_0000) begin
			rate = 20'h0_0001;
		end
		den = {12'h000, rate} * 32'(TQ_PER_BIT);
		// Rounded quotient picks the closest reachable rate
		quo = (32'(CLK_HZ) + (den >> 1)) / den;
		if (quo == 32'h0000_0000) begin
			next_st.t.prescaler = 16'h0001;
		end else if (quo > 32'h0000_FFFF) begin
			next_st.t.prescaler = 16'hFFFF;
		end else begin
			next_st.t.prescaler = quo[15:0];
		end
		sp = samplePointTq;
		if (sp < 5'h02) begin
			sp = 5'h02;
		end else if (sp > TQ - 5'h01) begin
			sp = TQ - 5'h01;
		end
		next_st.t.tseg1 = sp - 5'h01;
		next_st.t.tseg2 = TQ - sp;
		if (resyncJumpWidth == 2'h0) begin
			next_st.t.resync_jump_width = 2'h1;
		end else if ({3'h0, resyncJumpWidth} > TQ - sp) begin
			next_st.t.resync_jump_width = 2'((TQ - sp));
		end else begin
			next_st.t.resync_jump_width = resyncJumpWidth;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st.t.prescaler <= PRESCALER_RST;
			st.t.tseg1 <= SAMPLE_TQ_RST - 5'h01;
			st.t.tseg2 <= TQ - SAMPLE_TQ_RST;
			st.t.resync_jump_width <= SJW_RST;
		end else begin
			st <= next_st;
		end
	end

	assign timing = st.t;

endmodule

// ===== hdl/ucfb_bridge.sv
// Serial-to-CAN bridge core: parser, pair-mode packer and frame-to-text emitter.
// Assumes a UART byte receiver/transmitter and a CAN controller on this clock.
`timescale 1ns/1ps

module ucfb_bridge import ucfb_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF,
	parameter int TQ_PER_BIT = TQ_PER_BIT_DEF
) (
	input wire logic clk,
	input wire logic sys_rst,
	input ucfb_mode_t commMode,
	input wire logic idExtended,
	input wire logic [3:0] rateSel,
	input wire logic useUserRate,
	input wire logic [19:0] userRateBps,
	input wire logic [4:0] samplePointTq,
	input wire logic [1:0] resyncJumpWidth,
	input wire logic [28:0] accCode,
	input wire logic [28:0] accMask,
	input wire logic [28:0] fixedId,
	input wire logic respondWithId,
	input ucfb_end_t endSel,
	input wire logic [7:0] userEnd1,
	input wire logic [7:0] userEnd2,
	input wire logic [15:0] canTimeoutMs,
	input wire logic [15:0] uartTimeoutMs,
	input wire logic uartRxValid,
	input wire logic [7:0] uartRxData,
	output logic uartRxReady,
	output logic uartTxValid,
	output logic [7:0] uartTxData,
	input wire logic uartTxReady,
	output logic uartCmdError,
	output logic canTxValid,
	output ucfb_frame_t canTxFrame,
	input wire logic canTxReady,
	input wire logic canRxValid,
	input ucfb_frame_t canRxFrame,
	output logic canRxReady,
	output logic canSilent,
	output ucfb_timing_t canTiming
);

	typedef enum {P_CMD, P_ID, P_LEN, P_DATA, P_END, P_SKIP} ucfb_parse_t;

	typedef struct packed {
		ucfb_parse_t pState;
		logic [3:0] nib;
		logic pExt;
		ucfb_frame_t txF;
		logic txPending;
		logic prevMatch;
		ucfb_frame_t rxF;
		logic rxHeld;
		logic emitting;
		logic [5:0] pos;
		logic [7:0] outByte;
		logic errPulse;
	} ucfb_state_t;

	ucfb_state_t st;
	ucfb_state_t next_st;
	logic rxTake;
	logic accept;
	logic canExpired;
	logic uartExpired;
	logic [4:0] hv;
	logic [7:0] endFirst;
	logic [7:0] endSecond;
	logic [1:0] endLen;
	logic [28:0] fMask;
	logic m1;
	logic m2;
	logic [3:0] cnt;
	logic [3:0] newDlc;
	logic [3:0] nidParse;
	logic isPair;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [5:0] frameLen(input ucfb_frame_t f, input logic pair,
		input logic withId);
		if (pair) begin
			frameLen = (withId ? (f.ext ? 6'd4 : 6'd2) : 6'd0) + {2'b00, f.dlc};
		end else begin
			frameLen = (f.ext ? 6'd8 : 6'd3) + {1'b0, f.dlc, 1'b0} + 6'd3;
		end
	endfunction

	function automatic logic [7:0] charAt(input logic [5:0] p, input ucfb_frame_t f,
		input logic pair, input logic withId);
		logic [31:0] idPad;
		logic [5:0] nid;
		logic [5:0] j;
		logic [7:0] b;
		idPad = {3'b000, f.id};
		charAt = CH_CR;
		if (pair) begin
			nid = withId ? (f.ext ? 6'd4 : 6'd2) : 6'd0;
			if (p < nid) begin
				charAt = 8'(idPad >> {(nid - 6'd1 - p), 3'b000});
			end else begin
				j = p - nid;
				charAt = f.data[{j[2:0], 3'b000} +: 8];
			end
		end else begin
			nid = f.ext ? 6'd8 : 6'd3;
			if (p == 6'd0) begin
				charAt = f.ext ? CH_EXT : CH_STD;
			end else if (p <= nid) begin
				charAt = hexChar(4'(idPad >> {(nid - p), 2'b00}));
			end else if (p == nid + 6'd1) begin
				charAt = hexChar(f.dlc);
			end else if (p < nid + 6'd2 + {1'b0, f.dlc, 1'b0}) begin
				j = p - nid - 6'd2;
				b = f.data[{j[3:1], 3'b000} +: 8];
				charAt = hexChar(j[0] ? b[3:0] : b[7:4]);
			end
		end
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	ucfb_bit_timing #(.TQ_PER_BIT(TQ_PER_BIT)) bitTiming (
		.clk(clk),
		.sys_rst(sys_rst),
		.rateSel(rateSel),
		.useUserRate(useUserRate),
		.userRateBps(userRateBps),
		.samplePointTq(samplePointTq),
		.resyncJumpWidth(resyncJumpWidth),
		.timing(canTiming)
	);

	ucfb_ms_timeout #(.MS_CYCLES(MS_CYCLES)) canTimer (
		.clk(clk),
		.sys_rst(sys_rst),
		.restart(accept),
		.limitMs(canTimeoutMs),
		.expired(canExpired)
	);

	ucfb_ms_timeout #(.MS_CYCLES(MS_CYCLES)) uartTimer (
		.clk(clk),
		.sys_rst(sys_rst),
		.restart(rxTake),
		.limitMs(uartTimeoutMs),
		.expired(uartExpired)
	);

	// ----------------------------------------
	// End sequence selection
	// ----------------------------------------
	always_comb begin
		endFirst = CH_CR;
		endSecond = CH_LF;
		endLen = 2'd1;
		case (endSel)
			END_NONE: endLen = 2'd0;
			END_CR: endFirst = CH_CR;
			END_LF: endFirst = CH_LF;
			END_CRLF: endLen = 2'd2;
			END_LFCR: begin
				endFirst = CH_LF;
				endSecond = CH_CR;
				endLen = 2'd2;
			end
			END_USER1: endFirst = userEnd1;
			END_USER2: begin
				endFirst = userEnd1;
				endSecond = userEnd2;
				endLen = 2'd2;
			end
			default: endLen = 2'd0;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.errPulse = 1'b0;
		isPair = (commMode == MODE_PAIR);
		rxTake = uartRxValid && !st.txPending;
		hv = hexVal(uartRxData);
		nidParse = st.pExt ? 4'd8 : 4'd3;
		cnt = st.txF.dlc;
		newDlc = cnt;
		m1 = 1'b0;
		m2 = 1'b0;
		fMask = canRxFrame.ext ? accMask : (accMask & STD_ID_MASK);
		accept = 1'b0;

		if (canTxValid && canTxReady) begin
			next_st.txPending = 1'b0;
			next_st.txF = '0;
		end

		if (rxTake && isPair) begin
			// Byte order kept: byte 0 leaves first
			next_st.txF.data[{cnt[2:0], 3'b000} +: 8] = uartRxData;
			next_st.txF.ext = idExtended;
			next_st.txF.id = idExtended ? fixedId : (fixedId & STD_ID_MASK);
			m1 = (endLen == 2'd1) && (uartRxData == endFirst);
			m2 = (endLen == 2'd2) && st.prevMatch && (uartRxData == endSecond);
			if (m1) begin
				newDlc = cnt;
			end else if (m2) begin
				// First end byte may already sit in a frame that left
				newDlc = (cnt == 4'd0) ? 4'd0 : cnt - 4'd1;
			end else begin
				newDlc = cnt + 4'd1;
			end
			next_st.txF.dlc = newDlc;
			next_st.txF.data = next_st.txF.data & ~(64'hFFFF_FFFF_FFFF_FFFF << {newDlc, 3'b000});
			next_st.txPending = (m1 || m2) ? (newDlc != 4'd0) : (newDlc == MAX_DLC);
			next_st.prevMatch = (endLen == 2'd2) && (uartRxData == endFirst) && !m2;
		end else if (rxTake) begin
			case (st.pState)
				P_CMD: begin
					next_st.txF = '0;
					next_st.nib = 4'd0;
					if (uartRxData == CH_STD) begin
						next_st.pExt = 1'b0;
						next_st.pState = P_ID;
					end else if (uartRxData == CH_EXT && idExtended) begin
						next_st.pExt = 1'b1;
						next_st.pState = P_ID;
					end else begin
						next_st.errPulse = 1'b1;
						next_st.pState = (uartRxData == CH_CR) ? P_CMD : P_SKIP;
					end
				end
				P_ID: begin
					if (hv[4]) begin
						next_st.txF.id = {st.txF.id[24:0], hv[3:0]};
						next_st.nib = st.nib + 4'd1;
						if (st.nib == nidParse - 4'd1) begin
							next_st.nib = 4'd0;
							next_st.pState = P_LEN;
						end
					end else begin
						next_st.errPulse = 1'b1;
						next_st.pState = (uartRxData == CH_CR) ? P_CMD : P_SKIP;
					end
				end
				P_LEN: begin
					if (hv[4] && hv[3:0] <= MAX_DLC) begin
						next_st.txF.dlc = hv[3:0];
						next_st.pState = (hv[3:0] == 4'd0) ? P_END : P_DATA;
					end else begin
						next_st.errPulse = 1'b1;
						next_st.pState = (uartRxData == CH_CR) ? P_CMD : P_SKIP;
					end
				end
				P_DATA: begin
					if (hv[4]) begin
						next_st.txF.data[{st.nib[3:1], ~st.nib[0], 2'b00} +: 4] = hv[3:0];
						next_st.nib = st.nib + 4'd1;
						if ({1'b0, st.nib} == {st.txF.dlc, 1'b0} - 5'd1) begin
							next_st.pState = P_END;
						end
					end else begin
						next_st.errPulse = 1'b1;
						next_st.pState = (uartRxData == CH_CR) ? P_CMD : P_SKIP;
					end
				end
				P_END: begin
					if (uartRxData == CH_CR) begin
						next_st.txF.ext = st.pExt;
						next_st.txF.id = st.pExt ? st.txF.id : (st.txF.id & STD_ID_MASK);
						// Listen-only swallows well-formed commands
						next_st.txPending = (commMode != MODE_LISTEN);
						next_st.pState = P_CMD;
					end else begin
						next_st.errPulse = 1'b1;
						next_st.pState = P_SKIP;
					end
				end
				P_SKIP: begin
					if (uartRxData == CH_CR) begin
						next_st.pState = P_CMD;
					end
				end
				default: next_st.pState = P_CMD;
			endcase
		end

		// Timeout flush only when no end sequence is set
		if (isPair && endLen == 2'd0 && !st.txPending && st.txF.dlc != 4'd0
			&& !rxTake && uartExpired) begin
			next_st.txPending = 1'b1;
		end

		// Frames failing the filter are consumed and dropped
		if (canRxValid && !st.rxHeld) begin
			accept = (((canRxFrame.id ^ accCode) & fMask) == 29'h0000_0000)
				&& (idExtended || !canRxFrame.ext);
		end
		if (accept) begin
			next_st.rxHeld = 1'b1;
			next_st.rxF = canRxFrame;
			next_st.emitting = 1'b0;
			next_st.pos = 6'd0;
		end else if (st.rxHeld && !st.emitting && canExpired) begin
			if (frameLen(st.rxF, isPair, respondWithId) == 6'd0) begin
				next_st.rxHeld = 1'b0;
			end else begin
				next_st.emitting = 1'b1;
				next_st.pos = 6'd0;
			end
		end else if (st.emitting && uartTxReady) begin
			if (st.pos == frameLen(st.rxF, isPair, respondWithId) - 6'd1) begin
				next_st.emitting = 1'b0;
				next_st.rxHeld = 1'b0;
			end else begin
				next_st.pos = st.pos + 6'd1;
			end
		end
		next_st.outByte = charAt(next_st.pos, next_st.rxF, isPair, respondWithId);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign uartRxReady = !st.txPending;
	assign uartTxValid = st.emitting;
	assign uartTxData = st.outByte;
	assign uartCmdError = st.errPulse;
	assign canTxValid = st.txPending && (commMode != MODE_LISTEN);
	assign canTxFrame = st.txF;
	assign canRxReady = !st.rxHeld;
	assign canSilent = (commMode == MODE_LISTEN);

endmodule

// ===== tb/ucfb_bridge_sva.sv
// Port checker for the bridge core.
// Assumes a bind from the bench; one clock, async reset.
`timescale 1ns/1ps

module ucfb_bridge_sva import ucfb_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input ucfb_mode_t commMode,
	input wire logic idExtended,
	input wire logic uartRxReady,
	input wire logic uartTxValid,
	input wire logic [7:0] uartTxData,
	input wire logic uartTxReady,
	input wire logic uartCmdError,
	input wire logic canTxValid,
	input ucfb_frame_t canTxFrame,
	input wire logic canTxReady,
	input wire logic canSilent
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_silent; commMode == MODE_LISTEN |-> canSilent; endproperty
	a_silent: assert property (p_silent) else $error("listen not silent");
	property p_listenTx; commMode == MODE_LISTEN |-> !canTxValid; endproperty
	a_listenTx: assert property (p_listenTx) else $error("listen sends");
	property p_stall; commMode != MODE_LISTEN |-> uartRxReady != canTxValid; endproperty
	a_stall: assert property (p_stall) else $error("serial ready vs frame");
	property p_hold; canTxValid && !canTxReady |=> canTxValid && $stable(canTxFrame); endproperty
	a_hold: assert property (p_hold) else $error("frame not held");
	property p_drop; canTxValid && canTxReady |=> !canTxValid; endproperty
	a_drop: assert property (p_drop) else $error("frame sent twice");
	property p_uhold; uartTxValid && !uartTxReady |=> uartTxValid && $stable(uartTxData);
	endproperty
	a_uhold: assert property (p_uhold) else $error("serial byte not held");
	property p_dlc; canTxValid |-> canTxFrame.dlc <= MAX_DLC; endproperty
	a_dlc: assert property (p_dlc) else $error("length above eight");
	property p_std; canTxValid && !idExtended |-> !canTxFrame.ext && canTxFrame.id[28:11] == 0;
	endproperty
	a_std: assert property (p_std) else $error("long id in short mode");
	property p_pairLen; canTxValid && commMode == MODE_PAIR |-> canTxFrame.dlc != 4'h0;
	endproperty
	a_pairLen: assert property (p_pairLen) else $error("empty pair frame");
	property p_err; uartCmdError |-> commMode != MODE_PAIR; endproperty
	a_err: assert property (p_err) else $error("error in pair mode");
endmodule

// ===== tb/ucfb_can_node.sv
// CAN controller stand-in on the bridge frame ports.
// Assumes the bench calls sendFrame; accepted frames queue in got.
`timescale 1ns/1ps

module ucfb_can_node import ucfb_pkg::*; (
	input wire logic clk,
	input wire logic canTxValid,
	input ucfb_frame_t canTxFrame,
	output logic canTxReady,
	output logic canRxValid,
	output ucfb_frame_t canRxFrame,
	input wire logic canRxReady
);
	ucfb_frame_t got[$];
	int cnt = 0;
	initial begin
		canTxReady = 1'b0;
		canRxValid = 1'b0;
		canRxFrame = '0;
	end
	// Ready one cycle in three, so held frames get exercised
	always @(posedge clk) begin
		canTxReady <= (cnt == 0);
		cnt <= (cnt >= 2) ? 0 : cnt + 1;
	end
	// Sampled mid-cycle to stay clear of the edge race
	always @(negedge clk) begin
		if (canTxValid && canTxReady) begin
			got.push_back(canTxFrame);
		end
	end
	// Offered ids are kept apart from the bridge fixed id
	task automatic sendFrame(input ucfb_frame_t f, output logic ok);
		int n;
		n = 0;
		@(posedge clk);
		canRxValid <= 1'b1;
		canRxFrame <= f;
		@(negedge clk);
		while (!canRxReady && n < 300) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		canRxValid <= 1'b0;
		canRxFrame <= ~f;
		ok = (n < 300);
	endtask
endmodule

// ===== tb/tb.sv
// Bench for the bridge core: serial host here, CAN side in the node model.
// Assumes a shortened millisecond of ten cycles.
`timescale 1ns/1ps

module tb import ucfb_pkg::*; ();
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	ucfb_mode_t commMode = MODE_NORMAL;
	ucfb_end_t endSel = END_CR;
	logic idExtended = 1'b0, useUserRate = 1'b0, respondWithId = 1'b0;
	logic [3:0] rateSel = 4'h3;
	logic [19:0] userRateBps = 20'h0_0000;
	logic [4:0] samplePointTq = 5'h0E;
	logic [1:0] resyncJumpWidth = 2'h1;
	logic [28:0] accCode = '0, accMask = '0, fixedId = 29'h0000_0321;
	logic [7:0] userEnd1 = 8'h3B, userEnd2 = 8'h21, uartRxData = 8'h00, uartTxData;
	logic [15:0] canTimeoutMs = 16'h0000, uartTimeoutMs = 16'h0001;
	logic uartRxValid = 1'b0, uartTxReady = 1'b0, ok;
	logic uartRxReady, uartTxValid, uartCmdError, canTxValid, canTxReady;
	logic canRxValid, canRxReady, canSilent;
	ucfb_frame_t canTxFrame, canRxFrame, f;
	ucfb_timing_t canTiming;
	int errors = 0, n_checks = 0, errPulses = 0, waited = 0;

	always #12.5 clk = ~clk;
	always @(negedge clk) if (uartCmdError === 1'b1) errPulses++;

	ucfb_bridge #(.MS_CYCLES(10)) DUT (.clk, .sys_rst, .commMode, .idExtended, .rateSel,
		.useUserRate, .userRateBps, .samplePointTq, .resyncJumpWidth, .accCode, .accMask,
		.fixedId, .respondWithId, .endSel, .userEnd1, .userEnd2, .canTimeoutMs,
		.uartTimeoutMs, .uartRxValid, .uartRxData, .uartRxReady, .uartTxValid, .uartTxData,
		.uartTxReady, .uartCmdError, .canTxValid, .canTxFrame, .canTxReady, .canRxValid,
		.canRxFrame, .canRxReady, .canSilent, .canTiming);
	ucfb_can_node u_node (.clk, .canTxValid, .canTxFrame, .canTxReady, .canRxValid,
		.canRxFrame, .canRxReady);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// 0 serial ready, 1 serial out valid, 2 frame queued
	task automatic waitFor(input int w);
		waited = 0;
		@(negedge clk);
		while (waited < 300 && !(w == 0 ? uartRxReady : w == 1 ? uartTxValid :
			u_node.got.size() > 0)) begin
			@(negedge clk);
			waited++;
		end
		if (waited >= 300) begin
			errors++;
			$display("BAD %0t wait ran out", $time);
			final_report();
		end
	endtask
	task automatic sendStr(input string s);
		@(posedge clk);
		for (int i = 0; i < s.len(); i++) begin
			uartRxValid <= 1'b1;
			uartRxData <= s[i];
			waitFor(0);
			@(posedge clk);
		end
		uartRxValid <= 1'b0;
		uartRxData <= ~uartRxData;
	endtask
	// First byte is stalled two cycles on purpose
	task automatic recvStr(input string s);
		waitFor(1);
		repeat (2) @(posedge clk);
		uartTxReady <= 1'b1;
		for (int i = 0; i < s.len(); i++) begin
			waitFor(1);
			chk(uartTxData, s[i]);
			@(posedge clk);
		end
		uartTxReady <= 1'b0;
		repeat (4) @(negedge clk);
		chk(uartTxValid, 1'b0);
	endtask
	task automatic getFrame();
		waitFor(2);
		f = u_node.got.pop_front();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_timing();
		logic [15:0] pr [9] = '{16'h00FA, 16'h007D, 16'h0032, 16'h0014, 16'h000A,
			16'h0005, 16'h0003, 16'h0003, 16'h001E};
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			rateSel <= i[3:0];
			repeat (3) @(posedge clk);
			chk(canTiming.prescaler, pr[i]);
		end
		useUserRate <= 1'b1;
		userRateBps <= 20'h1_1940;
		samplePointTq <= 5'h0C;
		resyncJumpWidth <= 2'h3;
		repeat (3) @(posedge clk);
		chk(canTiming.prescaler, 16'h0023);
		chk({canTiming.tseg1, canTiming.tseg2, canTiming.resync_jump_width}, {5'h0B, 5'h04, 2'h3});
		useUserRate <= 1'b0;
		samplePointTq <= 5'h0E;
		resyncJumpWidth <= 2'h1;
		rateSel <= 4'h3;
		repeat (3) @(posedge clk);
		chk({canTiming.tseg1, canTiming.tseg2, canTiming.resync_jump_width}, {5'h0D, 5'h02, 2'h1});
		$display("t_timing done");
	endtask
	task automatic t_normal();
		int e;
		sendStr("t1231AB\015");
		getFrame();
		chk(f, {1'b0, 29'h0000_0123, 4'h1, 64'h0000_0000_0000_00AB});
		@(posedge clk);
		idExtended <= 1'b1;
		sendStr("e123456781AB\015");
		getFrame();
		chk(f, {1'b1, 29'h1234_5678, 4'h1, 64'h0000_0000_0000_00AB});
		@(posedge clk);
		idExtended <= 1'b0;
		e = errPulses;
		sendStr("x\015");
		repeat (4) @(posedge clk);
		chk(errPulses - e, 1);
		chk(u_node.got.size(), 0);
		$display("t_normal done");
	endtask
	task automatic t_canrx();
		u_node.sendFrame({1'b0, 29'h0000_0123, 4'h1, 64'h0000_0000_0000_005A}, ok);
		chk(ok, 1'b1);
		recvStr("t12315A\015");
		@(posedge clk);
		accCode <= 29'h0000_0100;
		accMask <= 29'h0000_07FF;
		u_node.sendFrame({1'b0, 29'h0000_0123, 4'h1, 64'h0000_0000_0000_005A}, ok);
		chk(ok, 1'b1);
		repeat (20) @(negedge clk);
		chk(uartTxValid, 1'b0);
		chk(canRxReady, 1'b1);
		@(posedge clk);
		accMask <= '0;
		canTimeoutMs <= 16'h0002;
		u_node.sendFrame({1'b0, 29'h0000_0100, 4'h0, 64'h0000_0000_0000_0000}, ok);
		chk(ok, 1'b1);
		waitFor(1);
		chk(waited >= 18 && waited <= 25, 1'b1);
		chk(canRxReady, 1'b0);
		recvStr("t1000\015");
		@(posedge clk);
		canTimeoutMs <= 16'h0000;
		$display("t_canrx done");
	endtask
	task automatic t_pair();
		ucfb_end_t ends [6] = '{END_CR, END_LF, END_CRLF, END_LFCR, END_USER1, END_USER2};
		string txt [6] = '{"C\015", "C\012", "C\015\012", "C\012\015", "C;", "C;!"};
		@(posedge clk);
		commMode <= MODE_PAIR;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			endSel <= ends[i];
			sendStr(txt[i]);
			getFrame();
			chk(f, {1'b0, 29'h0000_0321, 4'h1, 64'h0000_0000_0000_0043});
		end
		@(posedge clk);
		endSel <= END_NONE;
		sendStr("012345678");
		getFrame();
		chk(f, {1'b0, 29'h0000_0321, 4'h8, 64'h3736_3534_3332_3130});
		repeat (5) @(negedge clk);
		chk(u_node.got.size(), 0);
		getFrame();
		chk(f, {1'b0, 29'h0000_0321, 4'h1, 64'h0000_0000_0000_0038});
		@(posedge clk);
		respondWithId <= 1'b1;
		u_node.sendFrame({1'b0, 29'h0000_0123, 4'h2, 64'h0000_0000_0000_BEEF}, ok);
		chk(ok, 1'b1);
		recvStr("\001\043\357\276");
		@(posedge clk);
		respondWithId <= 1'b0;
		u_node.sendFrame({1'b0, 29'h0000_0123, 4'h2, 64'h0000_0000_0000_BEEF}, ok);
		chk(ok, 1'b1);
		recvStr("\357\276");
		$display("t_pair done");
	endtask
	task automatic t_listen();
		@(posedge clk);
		commMode <= MODE_LISTEN;
		sendStr("t1231AB\015");
		repeat (5) @(negedge clk);
		chk(canSilent, 1'b1);
		chk(u_node.got.size(), 0);
		chk(uartRxReady, 1'b1);
		@(posedge clk);
		commMode <= MODE_NORMAL;
		$display("t_listen done");
	endtask

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_timing();
		t_normal();
		t_canrx();
		t_pair();
		t_listen();
		final_report();
	end
endmodule

bind ucfb_bridge ucfb_bridge_sva u_sva (.clk, .sys_rst, .commMode, .idExtended, .uartRxReady,
	.uartTxValid, .uartTxData, .uartTxReady, .uartCmdError, .canTxValid, .canTxFrame,
	.canTxReady, .canSilent);
